/* File: verilog/lac_params.svh */
/*
  Constants of the loop alarm comparator: mode codes, field positions,
  reset values and widths. Definitions only; included by every file of
  the block that needs a figure.
*/
`ifndef LAC_PARAMS_SVH
`define LAC_PARAMS_SVH

// Alarm mode codes held in each nibble of the mode word
`define LAC_MODE_NONE 4'h0
`define LAC_MODE_UPLO 4'h1
`define LAC_MODE_UPPER 4'h2
`define LAC_MODE_LOWER 4'h3
`define LAC_MODE_RANGE 4'h4
`define LAC_MODE_UPLO_SB 4'h5
`define LAC_MODE_UPPER_SB 4'h6
`define LAC_MODE_LOWER_SB 4'h7
`define LAC_MODE_ABS_UPPER 4'h8
`define LAC_MODE_ABS_LOWER 4'h9
`define LAC_MODE_LOOP_OFF 4'hF

// Mode word layout: loop 1 alarm 1 in the top nibble
`define LAC_MODE_TOP_BIT 15
`define LAC_NIBBLE 4

// Reset values: factory mode 0, hysteresis 0.2 in 0.1 units
`define LAC_MODE_WORD_RST 16'h0000
`define LAC_HYST_RST 16'h0002

// Alarms per unit and widths of words and of the compare path
`define LAC_ALARMS 4
`define LAC_LOOPS 2
`define LAC_WORD 16
`define LAC_CMP 18

`endif

/* File: verilog/lac_pkg.sv */
/*
  Types of the loop alarm comparator: register-state structs of the
  top and of the configuration latch. Figures live in lac_params.svh.
*/
`default_nettype none

package lac_pkg;

  typedef logic [3:0] lac_code_t;

  // State of the four alarm evaluators
  typedef struct packed {
    logic [3:0] rawOn;    // Comparison result with hysteresis
    logic [3:0] standby;  // Standby suppression armed
    logic [3:0] outOn;    // Alarm outputs
    logic [1:0] offPrev;  // Output-off flags, previous cycle
  } lac_alarm_state_t;

  // State of the configuration latch
  typedef struct packed {
    logic loadPending;
    logic [15:0] modeWord;
    logic [3:0][15:0] hyst;
  } lac_cfg_state_t;

endpackage

`default_nettype wire

/* File: verilog/lac_cfg_if.sv */
/*
  Carrier for the latched alarm configuration between the latch and the
  alarm evaluators. Assumes one clock domain for both ends.
*/
`timescale 1ns/1ns
`default_nettype none

interface lac_cfg_if;
  logic [3:0][3:0] mode;   // Active mode per alarm, index 0 = loop 1 alarm 1
  logic [3:0][15:0] hyst;  // Active hysteresis per alarm
  logic load;              // Configuration taken this cycle
  modport src (output mode, output hyst, output load);
  modport snk (input mode, input hyst, input load);
endinterface

`default_nettype wire

/* File: verilog/lac_cfg_latch.sv */
/*
  Configuration latch: takes the mode word and the four hysteresis words
  at the first clock after reset release and on each unit restart, and
  holds them otherwise. Assumes the inputs are on clk's domain.
*/
`timescale 1ns/1ns
`default_nettype none
`include "lac_params.svh"

module lac_cfg_latch (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host words and restart
  input wire logic unitRestart,
  input wire logic [15:0] modeWordIn,
  input wire logic [3:0][15:0] hystIn,
  // Latched configuration
  lac_cfg_if.src cfg
);

  lac_pkg::lac_cfg_state_t state_reg;
  lac_pkg::lac_cfg_state_t state_next;
  logic load;

  // Load on restart, or once after reset since ports cannot be caught
  // under the asynchronous reset itself
  assign load = state_reg.loadPending | unitRestart;

  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.loadPending = 1'b0;
    if (load) begin
      state_next.modeWord = modeWordIn;
      state_next.hyst = hystIn;
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg.loadPending <= 1'b1;
      state_reg.modeWord <= `LAC_MODE_WORD_RST;
      state_reg.hyst <= {4{`LAC_HYST_RST}};
    end else begin
      state_reg <= state_next;
    end
  end

  // Split the mode word into nibbles, top nibble first
  always_comb begin
    for (int i = 0; i < `LAC_ALARMS; i++) begin
      cfg.mode[i] = state_reg.modeWord[`LAC_MODE_TOP_BIT - `LAC_NIBBLE*i -: 4];
    end
  end
  assign cfg.hyst = state_reg.hyst;
  assign cfg.load = load;

endmodule

`default_nettype wire

/* File: verilog/lac_change_detect.sv */
/*
  Change detector: pulses for one cycle when a word differs from its
  value in the previous cycle. Silent in the first cycle after reset.
  Assumes the word is on clk's domain.
*/
`timescale 1ns/1ns
`default_nettype none

module lac_change_detect #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Watched word and change pulse
  input wire logic [WIDTH-1:0] value,
  output logic changed
);

  typedef struct packed {
    logic primed;
    logic [WIDTH-1:0] prev;
  } lac_chg_state_t;

  lac_chg_state_t state_reg;
  lac_chg_state_t state_next;

  if (WIDTH < 1) begin : g_bad_width
    $error("lac_change_detect: WIDTH must be at least 1");
  end

  // Compare against last cycle's copy
  assign changed = state_reg.primed && (value != state_reg.prev);

  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.primed = 1'b1;
    state_next.prev = value;
  end

  // Registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

`default_nettype wire

/* File: verilog/lac_alarm_top.sv */
/*
  Loop alarm comparator for a two-loop temperature controller: four alarm
  outputs, two per loop, each with mode, hysteresis, level and standby.
  Assumes all inputs come from logic on clk; the host holds the words
  steady and pulses unitRestart after changing mode or hysteresis.
*/
// Functional notes
// - Two independent alarms per loop, each with mode, hysteresis, level.
// - Mode codes 0 to 9 select none, deviation, range, standby, absolute.
// - Mode resets to 0, and mode 0 keeps the alarm off.
// - New mode takes effect only on restart or reset; host restarts.
// - Range mode 4 with a negative level keeps the alarm off.
// - Mode 5 with a negative level keeps the alarm off.
// - Each alarm has its own unsigned hysteresis, default 0.2.
// - New hysteresis takes effect only on restart or reset; host restarts.
// - Each alarm compares against its own signed level.
// - Standby hides the alarm until the value first leaves the range.
// - Lower alarm with standby waits for rise above, then fall below.
// - Standby re-arms on start, level, compensation or set point change.
// - Standby re-arms when the output-off flag goes from on to off.
// - Mode word holds four nibbles; code F on both disables a loop.
`timescale 1ns/1ns
`default_nettype none
`include "lac_params.svh"

module lac_alarm_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host restart and configuration words
  input wire logic unitRestart,
  input wire logic [15:0] alarmModeWord,
  input wire logic [15:0] loop1Alarm1Hysteresis,
  input wire logic [15:0] loop1Alarm2Hysteresis,
  input wire logic [15:0] loop2Alarm1Hysteresis,
  input wire logic [15:0] loop2Alarm2Hysteresis,
  input wire logic [15:0] loop1Alarm1Level,
  input wire logic [15:0] loop1Alarm2Level,
  input wire logic [15:0] loop2Alarm1Level,
  input wire logic [15:0] loop2Alarm2Level,
  // Loop measurements and settings
  input wire logic [15:0] processValue1,
  input wire logic [15:0] processValue2,
  input wire logic [15:0] setPoint1,
  input wire logic [15:0] setPoint2,
  input wire logic [15:0] inputCompensation1,
  input wire logic [15:0] inputCompensation2,
  input wire logic [1:0] outputOff,
  // Alarm outputs and readback
  output logic [3:0] alarmOut,
  output logic [15:0] activeModeWord,
  output logic [1:0] loopDisabled
);

  lac_cfg_if cfg ();

  lac_pkg::lac_alarm_state_t state_reg;
  lac_pkg::lac_alarm_state_t state_next;

  logic [3:0][15:0] levelVec;
  logic [1:0][15:0] pvVec;
  logic [1:0][15:0] spVec;
  logic [7:0][15:0] watchVec;
  logic [7:0] watchChg;
  logic signed [`LAC_CMP-1:0] devA [4];
  logic signed [`LAC_CMP-1:0] pvA [4];
  logic signed [`LAC_CMP-1:0] lvA [4];
  logic signed [`LAC_CMP-1:0] hyA [4];
  logic [3:0] rearm;
  logic [3:0] rawEval;
  logic [1:0] offFall;

  // mode and hysteresis held until restart
  lac_cfg_latch u_cfg (
    .clk(clk),
    .rst_b(rst_b),
    .unitRestart(unitRestart),
    .modeWordIn(alarmModeWord),
    .hystIn({loop2Alarm2Hysteresis, loop2Alarm1Hysteresis,
             loop1Alarm2Hysteresis, loop1Alarm1Hysteresis}),
    .cfg(cfg)
  );

  // Gather per-alarm and per-loop words, index 0 = loop 1 alarm 1
  assign levelVec = {loop2Alarm2Level, loop2Alarm1Level,
                     loop1Alarm2Level, loop1Alarm1Level};
  assign pvVec = {processValue2, processValue1};
  assign spVec = {setPoint2, setPoint1};
  assign watchVec = {inputCompensation2, inputCompensation1,
                     setPoint2, setPoint1, levelVec};

  // watch levels, set points and compensation
  for (genvar w = 0; w < 8; w++) begin : g_watch
    lac_change_detect #(.WIDTH(`LAC_WORD)) u_chg (
      .clk(clk),
      .rst_b(rst_b),
      .value(watchVec[w]),
      .changed(watchChg[w])
    );
  end

  assign offFall = state_reg.offPrev & ~outputOff;

  // one compare path per alarm, own level and hysteresis
  for (genvar a = 0; a < `LAC_ALARMS; a++) begin : g_path
    // deviation from set point, widened so nothing overflows
    assign pvA[a] = `LAC_CMP'($signed(pvVec[a/2]));
    assign devA[a] = `LAC_CMP'($signed(pvVec[a/2]))
                   - `LAC_CMP'($signed(spVec[a/2]));
    assign lvA[a] = `LAC_CMP'($signed(levelVec[a]));
    assign hyA[a] = $signed({2'h0, cfg.hyst[a]});
    // any re-arm cause for this alarm
    assign rearm[a] = cfg.load | watchChg[a] | watchChg[4 + a/2]
                    | watchChg[6 + a/2] | offFall[a/2];
    assign rawEval[a] = evalRaw(cfg.mode[a], devA[a], pvA[a], lvA[a],
                                hyA[a], state_reg.rawOn[a] & ~cfg.load);
  end

  // Alarm decision for one alarm. The thresholds relax by the hysteresis
  // only while the alarm is on, so it clears past threshold plus band.
  function automatic logic evalRaw(
    input logic [3:0] mode,
    input logic signed [`LAC_CMP-1:0] dev,
    input logic signed [`LAC_CMP-1:0] pv,
    input logic signed [`LAC_CMP-1:0] lv,
    input logic signed [`LAC_CMP-1:0] hy,
    input logic wasOn
  );
    logic signed [`LAC_CMP-1:0] q;
    logic signed [`LAC_CMP-1:0] hw;
    logic up;
    logic lo;
    logic neg;
    logic r;
    // absolute modes compare the raw value
    q = (mode == `LAC_MODE_ABS_UPPER || mode == `LAC_MODE_ABS_LOWER)
      ? pv : dev;
    // band applies only to the release side
    hw = wasOn ? hy : '0;
    up = q >= lv - hw;
    lo = q <= hw - lv;
    neg = lv < 0;
    case (mode)
      `LAC_MODE_UPLO: r = neg ? 1'b1 : (up | lo);
      // negative level holds mode 5 off
      `LAC_MODE_UPLO_SB: r = neg ? 1'b0 : (up | lo);
      `LAC_MODE_UPPER, `LAC_MODE_UPPER_SB: r = up;
      `LAC_MODE_LOWER, `LAC_MODE_LOWER_SB: r = lo;
      // negative level holds range mode off
      `LAC_MODE_RANGE: r = neg ? 1'b0 : (q <= lv + hw && q >= -lv - hw);
      `LAC_MODE_ABS_UPPER: r = up;
      `LAC_MODE_ABS_LOWER: r = q <= lv + hw;
      // mode 0 and unused codes give no alarm
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Next state of the four alarms
  always_comb begin
    logic enabled;
    logic sbMode;
    enabled = 1'b0;
    sbMode = 1'b0;
    state_next = state_reg;
    state_next.offPrev = outputOff;
    for (int i = 0; i < `LAC_ALARMS; i++) begin
      // code F on both alarms of a loop silences that loop
      enabled = !(cfg.mode[2*(i/2)] == `LAC_MODE_LOOP_OFF
                  && cfg.mode[2*(i/2)+1] == `LAC_MODE_LOOP_OFF);
      sbMode = cfg.mode[i] == `LAC_MODE_UPLO_SB
            || cfg.mode[i] == `LAC_MODE_UPPER_SB
            || cfg.mode[i] == `LAC_MODE_LOWER_SB;
      state_next.rawOn[i] = enabled & rawEval[i];
      // standby clears once the value is out of range
      // a re-arm in the same cycle wins over the clear
      state_next.standby[i] = rearm[i]
                            | (state_reg.standby[i] & state_next.rawOn[i]);
      state_next.outOn[i] = state_next.rawOn[i]
                          & ~(sbMode & state_next.standby[i]);
    end
  end

  // Registers; standby armed from power-up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg.rawOn <= 4'h0;
      state_reg.standby <= 4'hF;
      state_reg.outOn <= 4'h0;
      state_reg.offPrev <= 2'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign alarmOut = state_reg.outOn;
  assign activeModeWord = {cfg.mode[0], cfg.mode[1], cfg.mode[2], cfg.mode[3]};
  assign loopDisabled[0] = cfg.mode[0] == `LAC_MODE_LOOP_OFF
                        && cfg.mode[1] == `LAC_MODE_LOOP_OFF;
  assign loopDisabled[1] = cfg.mode[2] == `LAC_MODE_LOOP_OFF
                        && cfg.mode[3] == `LAC_MODE_LOOP_OFF;

  // Checks, all on clk, quiet during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  for (genvar k = 0; k < `LAC_ALARMS; k++) begin : g_chk
    a_mode_none_off: assert property (
      cfg.mode[k] == `LAC_MODE_NONE |=> !alarmOut[k])
      else $error("alarm on in mode 0");

    a_range_neg_off: assert property (
      cfg.mode[k] == `LAC_MODE_RANGE && lvA[k] < 0 |=> !alarmOut[k])
      else $error("range alarm on with negative level");

    a_stby_neg_off: assert property (
      cfg.mode[k] == `LAC_MODE_UPLO_SB && lvA[k] < 0 |=> !alarmOut[k])
      else $error("mode 5 alarm on with negative level");
  end

  a_mode_hold: assert property (
    $changed(activeModeWord) |-> $past(cfg.load))
    else $error("active mode changed without restart");

  a_hyst_hold: assert property (
    $changed(cfg.hyst) |-> $past(cfg.load))
    else $error("active hysteresis changed without restart");

  a_rearm_blocks: assert property (
    cfg.mode[1] == `LAC_MODE_UPPER_SB && watchChg[1] && !cfg.load
    |=> !alarmOut[1] [*2])
    else $error("standby alarm on right after level change");

  a_offflag_rearm: assert property (
    cfg.mode[1] == `LAC_MODE_UPPER_SB && $fell(outputOff[0])
    |=> !alarmOut[1])
    else $error("standby alarm on after output-off fell");

  a_abs_upper_on: assert property (
    cfg.mode[3] == `LAC_MODE_ABS_UPPER && cfg.mode[2] != `LAC_MODE_LOOP_OFF
    && pvA[3] >= lvA[3] |=> alarmOut[3])
    else $error("absolute upper alarm missing");

  a_hyst_keeps_on: assert property (
    cfg.mode[1] == `LAC_MODE_UPPER && !cfg.load && alarmOut[1]
    && devA[1] >= lvA[1] - hyA[1] |=> alarmOut[1])
    else $error("alarm released inside hysteresis band");

  a_loop_silenced: assert property (
    loopDisabled[0] |=> alarmOut[1:0] == 2'h0)
    else $error("disabled loop shows an alarm");

  // Decision checks; each consequent holds whatever the hysteresis
  // memory says, so they stay true across restarts as well
  a_upper_dev_on: assert property (
    cfg.mode[1] == `LAC_MODE_UPPER && devA[1] >= lvA[1]
    |=> alarmOut[1])
    else $error("upper alarm missing above level");

  a_lower_dev_on: assert property (
    cfg.mode[0] == `LAC_MODE_LOWER && devA[0] <= -lvA[0]
    |=> alarmOut[0])
    else $error("lower alarm missing below level");

  a_range_in_on: assert property (
    cfg.mode[0] == `LAC_MODE_RANGE && lvA[0] >= 0
    && devA[0] <= lvA[0] && devA[0] >= -lvA[0] |=> alarmOut[0])
    else $error("range alarm missing inside range");

  a_uplo_neg_on: assert property (
    cfg.mode[3] == `LAC_MODE_UPLO && lvA[3] < 0
    |=> alarmOut[3])
    else $error("mode 1 alarm off with negative level");

  a_abs_lower_on: assert property (
    cfg.mode[2] == `LAC_MODE_ABS_LOWER && pvA[2] <= lvA[2]
    |=> alarmOut[2])
    else $error("absolute lower alarm missing");

  a_upper_release: assert property (
    cfg.mode[1] == `LAC_MODE_UPPER && devA[1] < lvA[1] - hyA[1]
    |=> !alarmOut[1])
    else $error("upper alarm held beyond hysteresis band");

  a_stby_hides: assert property (
    cfg.mode[0] == `LAC_MODE_LOWER_SB && state_reg.standby[0]
    && rawEval[0] |=> !alarmOut[0])
    else $error("standby lower alarm shown before first exit");

  a_stby_clears: assert property (
    cfg.mode[1] == `LAC_MODE_UPPER_SB && !state_reg.standby[1]
    && !rearm[1] && devA[1] >= lvA[1] |=> alarmOut[1])
    else $error("standby upper alarm missing after first exit");

endmodule

`default_nettype wire

/* File: test/lac_host_model.sv */
/*
  Host-side model of the comparator: holds the configuration words and
  the alarm levels, and pulses the restart with new mode or hysteresis when asked.
  Assumes its tasks are called from the falling edge of clk.
*/
`timescale 1ns/1ns
`default_nettype none

module lac_host_model (
  // Clock
  input wire logic clk,
  // Configuration words and restart
  output logic unitRestart,
  output logic [15:0] modeWord,
  output logic [3:0][15:0] hyst,
  output logic [3:0][15:0] level
);
  // Factory words before the first load
  initial begin
    unitRestart = 1'b0;
    modeWord = 16'h0000;
    hyst = '0;
    level = '0;
  end

  // Words change at a falling edge, so the restart pulse is one full cycle
  // restart raised at the same edge as the change, when rs is set
  task automatic load(input logic [15:0] m, input logic [3:0][15:0] h,
                      input logic rs);
    @(negedge clk);
    modeWord = m;
    hyst = h;
    unitRestart = rs;
    @(negedge clk);
    unitRestart = 1'b0;
  endtask

  // Levels are used live by the design, no restart needed
  task automatic set_levels(input logic [3:0][15:0] v);
    level = v;
  endtask
endmodule

`default_nettype wire

/* File: test/loop_alarm_comparator_test.sv */
/*
  Self-checking bench of the loop alarm comparator: the host model sets
  the configuration, the bench drives loop values and queues expectations.
  Assumes outputs settle one clock edge after the inputs that cause them.
*/
`timescale 1ns/1ns
`default_nettype none

module loop_alarm_comparator_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic restart;
  logic [15:0] modeW, pv1, pv2, sp1, sp2, comp1, comp2, modeExp;
  logic [3:0][15:0] hyst, level;
  logic [1:0] offF;
  logic [3:0] alarmOut;
  logic [15:0] activeModeWord;
  logic [1:0] loopDisabled;
  logic [21:0] expQ[$];
  logic [21:0] want;
  integer seed = 32'hEED4F5CB;
  int failCount = 0;
  int testsRun = 0;

  lac_host_model i_lac_host_model (
    .clk(clk), .unitRestart(restart), .modeWord(modeW),
    .hyst(hyst), .level(level));

  lac_alarm_top i_lac_alarm_top (
    .clk(clk), .rst_b(rst_b), .unitRestart(restart),
    .alarmModeWord(modeW),
    .loop1Alarm1Hysteresis(hyst[0]), .loop1Alarm2Hysteresis(hyst[1]),
    .loop2Alarm1Hysteresis(hyst[2]), .loop2Alarm2Hysteresis(hyst[3]),
    .loop1Alarm1Level(level[0]), .loop1Alarm2Level(level[1]),
    .loop2Alarm1Level(level[2]), .loop2Alarm2Level(level[3]),
    .processValue1(pv1), .processValue2(pv2),
    .setPoint1(sp1), .setPoint2(sp2),
    .inputCompensation1(comp1), .inputCompensation2(comp2),
    .outputOff(offF), .alarmOut(alarmOut),
    .activeModeWord(activeModeWord), .loopDisabled(loopDisabled));

  // 50 MHz clock
  always #10 clk = ~clk;

  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] %0t outputs %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One cycle of loop values; the note is the output after the next edge
  task automatic step(input int p1, input int p2, input logic [3:0] a,
                      input bit chk);
    @(negedge clk);
    pv1 = 16'(p1);
    pv2 = 16'(p2);
    if (chk)
      expQ.push_back({modeExp, modeExp[7:0] == 8'hFF,
                      modeExp[15:8] == 8'hFF, a});
  endtask

  // Outputs are read 2 ns after the edge, once its updates have landed
  always @(posedge clk) begin
    #2;
    if (expQ.size() > 0) begin
      want = expQ.pop_front();
      check({activeModeWord, loopDisabled, alarmOut}, want);
    end
  end

  // Watchdog at 5000 cycles, far beyond the 70 cycles the run needs
  initial begin
    #(20 * 5000);
    failCount++;
    final_report();
  end

  initial begin
    {pv1, pv2, sp1, sp2, comp1, comp2} = '0;
    offF = 2'b00;
    modeExp = 16'h0000;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (6) step($random(seed), $random(seed), 4'h0, 1'b1);
    sp2 = 16'h0014;
    i_lac_host_model.set_levels({16'h0032, {3{16'h000A}}});
    modeExp = 16'h3218;
    i_lac_host_model.load(16'h3218, {{3{16'h0002}}, 16'h0003}, 1'b1);
    step(0, 20, 4'h0, 1'b1);
    step(10, 50, 4'hE, 1'b1);
    step(8, 48, 4'hE, 1'b1);
    step(7, 47, 4'h4, 1'b1);
    step(-10, 10, 4'h5, 1'b1);
    step(-8, 12, 4'h5, 1'b1);
    step(-7, 13, 4'h1, 1'b1);
    step(-6, 20, 4'h0, 1'b1);
    i_lac_host_model.load(16'h0000, {4{16'h0000}}, 1'b0);
    step(10, 50, 4'hE, 1'b1);
    step(8, 48, 4'hE, 1'b1);
    i_lac_host_model.set_levels({16'hFFFB, 16'h0005, {2{16'hFFFB}}});
    modeExp = 16'h4591;
    i_lac_host_model.load(16'h4591, {4{16'h0002}}, 1'b1);
    step($random(seed), 5, 4'hC, 1'b1);
    step($random(seed), 7, 4'hC, 1'b1);
    // Bit 14 keeps pv1 clear of the range that the next levels open
    step($random(seed) | 32'h4000, 8, 4'h8, 1'b1);
    i_lac_host_model.set_levels({16'hFFFB, 16'h0005, 16'hFFFB, 16'h0005});
    step(0, 8, 4'h9, 1'b1);
    step(7, 8, 4'h9, 1'b1);
    step(8, 8, 4'h8, 1'b1);
    step(-20, 0, 4'h0, 1'b0);
    i_lac_host_model.set_levels({{2{16'h0000}}, {2{16'h000A}}});
    modeExp = 16'h7600;
    i_lac_host_model.load(16'h7600, {4{16'h0002}}, 1'b1);
    step(-20, 0, 4'h0, 1'b1);
    step(0, 0, 4'h0, 1'b1);
    step(-10, 0, 4'h1, 1'b1);
    step(0, 0, 4'h0, 1'b1);
    step(20, 0, 4'h2, 1'b1);
    for (int k = 0; k < 4; k++) begin
      // Let the last note be judged before the re-arm cause lands
      step(20, 0, 4'h0, 1'b0);
      case (k)
        0: sp1 = 16'h0001;
        1: comp1 = 16'h0003;
        2: offF = 2'b01;
        default: i_lac_host_model.set_levels({32'h0, 16'h000B, 16'h000A});
      endcase
      step(20, 0, 4'h0, 1'b0);
      offF = 2'b00;
      step(20, 0, 4'h0, 1'b0);
      step(20, 0, 4'h0, 1'b1);
      step(0, 0, 4'h0, 1'b1);
      step(20, 0, 4'h2, 1'b1);
    end
    // both codes F disable the loop
    step(20, 0, 4'h0, 1'b0);
    i_lac_host_model.set_levels({{2{16'h000A}}, 32'h0});
    modeExp = 16'hFF12;
    i_lac_host_model.load(16'hFF12, {4{16'h0002}}, 1'b1);
    step(-50, 40, 4'hC, 1'b1);
    step(50, 40, 4'hC, 1'b1);
    repeat (2) @(negedge clk);
    final_report();
  end
endmodule

`default_nettype wire
